/* bench/msw_host.sv */
/*
 Host model: single word AHB-Lite master for the register bank.
 Assumes hready is the slave's hreadyout; byte address is four times the index.
*/
module msw_host (
   input  wire         clk,
   input  wire         hready,
   input  wire  [31:0] hrdata,
   output logic        hsel,
   output logic [31:0] haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // Callers write only mapped registers
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {14'h0000, idx, 2'h0};
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? wd : 32'h0;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
endmodule

/* bench/msw_regs_monitor.sv */
/*
 Checker for msw_regs: bus answer, level reset and read formats.
 Assumes one clock clk and the synchronous reset sys_rst.
*/
`include "msw_consts.vh"

module msw_regs_monitor (
   input wire        clk,
   input wire        sys_rst,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire        hready,
   input wire [31:0] hwdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire        irq_q,
   input wire [23:0] overcurrent_level_q,
   input wire [23:0] overvoltage_level_q,
   input wire [23:0] voltage_dip_level_q
);
   logic        take_w;
   logic        rd_q;
   logic        wr_q;
   logic        wr_prev_q;
   logic [15:0] idx_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Mapped word transfer taken this edge
   assign take_w = hsel & htrans[1] & hready & (hsize == `MSW_HSIZE_WORD)
                   & (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'h0);

   always @(posedge clk) begin
      rd_q      <= !sys_rst & take_w & !hwrite;
      wr_q      <= !sys_rst & take_w & hwrite;
      wr_prev_q <= !sys_rst & wr_q;
      idx_q     <= haddr[17:2];
   end

   sequence s_rd(logic [15:0] lo, logic [15:0] hi);
      rd_q && !wr_prev_q && idx_q >= lo && idx_q <= hi;
   endsequence
   sequence s_wr(logic [15:0] ix);
      wr_q && idx_q == ix;
   endsequence

   property p_bus;
      hreadyout && !hresp;
   endproperty
   property p_lvl_rst;
      $fell(sys_rst) |-> overcurrent_level_q == 24'hffffff && overvoltage_level_q == 24'hffffff;
   endproperty
   property p_dip_rst;
      $fell(sys_rst) |-> voltage_dip_level_q == 24'h000000;
   endproperty
   property p_irq_rst;
      $fell(sys_rst) |-> !irq_q [*2];
   endproperty
   property p_oc_rd;
      s_rd(`MSW_IDX_OVERCURRENT, `MSW_IDX_OVERCURRENT) |-> hrdata == {8'h00, overcurrent_level_q};
   endproperty
   property p_ov_rd;
      s_rd(`MSW_IDX_OVERVOLTAGE, `MSW_IDX_OVERVOLTAGE) |-> hrdata == {8'h00, overvoltage_level_q};
   endproperty
   property p_dip_rd;
      s_rd(`MSW_IDX_VOLTAGE_DIP, `MSW_IDX_VOLTAGE_DIP) |-> hrdata == {8'h00, voltage_dip_level_q};
   endproperty
   property p_sext;
      s_rd(`MSW_IDX_A_CURRENT_WV, `MSW_IDX_C_REACTIVE) |-> hrdata[31:24] == {8{hrdata[23]}};
   endproperty
   property p_mav;
      s_rd(`MSW_IDX_A_CURRENT_MAV, `MSW_IDX_C_CURRENT_MAV) |-> hrdata[31:20] == 12'h000;
   endproperty
   property p_oc_wr;
      s_wr(`MSW_IDX_OVERCURRENT) |=>
         {8'h00, overcurrent_level_q} == ($past(hwdata) & 32'h00ffffff);
   endproperty

   a_bus:     assert property (p_bus) else $error("bus answer not ready or not okay");
   a_lvl_rst: assert property (p_lvl_rst) else $error("limit level reset wrong");
   a_dip_rst: assert property (p_dip_rst) else $error("dip level reset wrong");
   a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
   a_oc_rd:   assert property (p_oc_rd) else $error("overcurrent read wrong");
   a_ov_rd:   assert property (p_ov_rd) else $error("overvoltage read wrong");
   a_dip_rd:  assert property (p_dip_rd) else $error("dip level read wrong");
   a_sext:    assert property (p_sext) else $error("signed read not extended");
   a_mav:     assert property (p_mav) else $error("mean value upper bits set");
   a_oc_wr:   assert property (p_oc_wr) else $error("overcurrent write lost");
endmodule

bind msw_regs msw_regs_monitor mon_u (
   .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout,
   .hresp, .hrdata, .irq_q, .overcurrent_level_q, .overvoltage_level_q, .voltage_dip_level_q
);

/* bench/msw_regs_tb.sv */
/*
 Self-checking bench for msw_regs: host model on the bus, engine strobes here.
 Assumes a 100 MHz clock and synchronous active-high reset.
*/
`include "msw_consts.vh"

module msw_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [23:0] SV [7] = '{24'h800000, 24'h7fffff, 24'hffff00, 24'h000123,
                                       24'hfffffb, 24'h000005, 24'hfffff0};
   localparam logic [23:0] PV [6] = '{24'h800001, 24'h7ffffe, 24'hf00000, 24'h0abcde,
                                       24'hffffff, 24'h000000};
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel, hwrite, hreadyout, hresp, irq_q;
   logic [31:0] haddr, hwdata, hrdata;
   logic [31:0] cpk = 32'h0, vpk = 32'h0, ev0 = 32'h0, ev1 = 32'h0;
   logic [1:0]  htrans;
   logic [1:0]  power_mode = 2'h2;
   logic [2:0]  hsize;
   logic [2:0]  vld = 3'h0;
   logic [23:0] smp [7];
   logic [23:0] pwr [6];
   logic [23:0] oc_q, ov_q, dip_q;
   int          err_count = 0;
   int          checks = 0;

   always #5 clk = ~clk;

   msw_host host_u (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
                    .hsize, .hwdata);

   msw_regs dut_u (
      .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
      .hreadyout, .hresp, .hrdata, .irq_q, .power_mode, .sample_valid(vld[0]),
      .ia_sample(smp[0]), .ib_sample(smp[1]), .ic_sample(smp[2]), .in_sample(smp[3]),
      .va_sample(smp[4]), .vb_sample(smp[5]), .vc_sample(smp[6]), .power_valid(vld[1]),
      .a_active_in(pwr[0]), .b_active_in(pwr[1]), .c_active_in(pwr[2]),
      .a_reactive_in(pwr[3]), .b_reactive_in(pwr[4]), .c_reactive_in(pwr[5]),
      .peak_valid(vld[2]), .current_peak_in(cpk), .voltage_peak_in(vpk), .event0(ev0),
      .event1(ev1), .overcurrent_level_q(oc_q), .overvoltage_level_q(ov_q),
      .voltage_dip_level_q(dip_q));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      host_u.xfer(1'b0, idx, 32'h0, d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] v);
      logic [31:0] d;
      host_u.xfer(1'b1, idx, v, d);
   endtask
   task automatic pulse(input logic [2:0] m, input logic [31:0] e0, input logic [31:0] e1);
      @(posedge clk);
      vld <= m;
      ev0 <= e0;
      ev1 <= e1;
      @(posedge clk);
      vld <= 3'h0;
      ev0 <= 32'h0;
      ev1 <= 32'h0;
   endtask
   task automatic mav_run(input logic [1:0] m, input logic [23:0] a, b, c);
      power_mode <= m;
      smp[0] <= a;
      smp[1] <= b;
      smp[2] <= c;
      repeat (16) pulse(3'h1, 32'h0, 32'h0);
   endtask
   task automatic irq_chk(input logic [31:0] exp);
      repeat (2) @(negedge clk);
      chk({31'h0, irq_q}, exp);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #100us;
      err_count++;
      end_sim();
   end

   initial begin
      for (int i = 0; i < 7; i++) smp[i] = 24'h0;
      for (int i = 0; i < 6; i++) pwr[i] = 24'h0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(`MSW_IDX_OVERCURRENT, 32'h00ffffff);
      rd_chk(`MSW_IDX_OVERVOLTAGE, 32'h00ffffff);
      rd_chk(`MSW_IDX_VOLTAGE_DIP, 32'h0);
      rd_chk(`MSW_IDX_IRQ_ENABLE_0, 32'h0);
      rd_chk(`MSW_IDX_IRQ_ENABLE_1, 32'h0);
      rd_chk(16'he519, 32'h0);
      $display("reset test done");
      wr(`MSW_IDX_OVERCURRENT, 32'hffabcdef);
      rd_chk(`MSW_IDX_OVERCURRENT, 32'h00abcdef);
      wr(`MSW_IDX_VOLTAGE_DIP, 32'h12345678);
      rd_chk(`MSW_IDX_VOLTAGE_DIP, 32'h00345678);
      wr(`MSW_IDX_IRQ_ENABLE_1, 32'hdeadbeef);
      rd_chk(`MSW_IDX_IRQ_ENABLE_1, 32'hdeadbeef);
      wr(`MSW_IDX_IRQ_ENABLE_1, 32'h0);
      cpk <= 32'h87654321;
      vpk <= 32'h0badf00d;
      pulse(3'h4, 32'h0, 32'h0);
      wr(`MSW_IDX_CURRENT_PEAK, 32'h0);
      rd_chk(`MSW_IDX_CURRENT_PEAK, 32'h87654321);
      rd_chk(`MSW_IDX_VOLTAGE_PEAK, 32'h0badf00d);
      $display("read-write test done");
      for (int i = 0; i < 7; i++) smp[i] <= SV[i];
      for (int i = 0; i < 6; i++) pwr[i] <= PV[i];
      pulse(3'h3, 32'h0, 32'h0);
      for (int i = 0; i < 7; i++)
         rd_chk(`MSW_IDX_A_CURRENT_WV + 16'(i), {{8{SV[i][23]}}, SV[i]});
      for (int i = 0; i < 6; i++)
         rd_chk(`MSW_IDX_A_ACTIVE + 16'(i), {{8{PV[i][23]}}, PV[i]});
      rd_chk(`MSW_IDX_IRQ_STATUS_1, 32'h00080000);
      wr(`MSW_IDX_OVERCURRENT, 32'h00000100);
      smp[0] <= 24'hfffe00;
      pulse(3'h1, 32'h0, 32'h0);
      rd_chk(`MSW_IDX_IRQ_STATUS_1, 32'h000a0000);
      wr(`MSW_IDX_OVERVOLTAGE, 32'h00000004);
      rd_chk(`MSW_IDX_OVERVOLTAGE, 32'h00000004);
      pulse(3'h1, 32'h0, 32'h0);
      rd_chk(`MSW_IDX_IRQ_STATUS_1, 32'h000e0000);
      $display("sample test done");
      mav_run(`MSW_MODE_NORMAL, 24'h000100, 24'hffff00, 24'h000008);
      rd_chk(`MSW_IDX_A_CURRENT_MAV, 32'h20);
      rd_chk(`MSW_IDX_B_CURRENT_MAV, 32'h20);
      rd_chk(`MSW_IDX_C_CURRENT_MAV, 32'h1);
      mav_run(2'h3, 24'h7fffff, 24'h000000, 24'h000000);
      rd_chk(`MSW_IDX_A_CURRENT_MAV, 32'h20);
      mav_run(`MSW_MODE_REDUCED, 24'h000200, 24'hfffe00, 24'h000010);
      rd_chk(`MSW_IDX_A_CURRENT_MAV, 32'h40);
      rd_chk(`MSW_IDX_B_CURRENT_MAV, 32'h40);
      rd_chk(`MSW_IDX_C_CURRENT_MAV, 32'h2);
      $display("mean value test done");
      wr(`MSW_IDX_IRQ_STATUS_0, 32'hffffffff);
      wr(`MSW_IDX_IRQ_STATUS_1, 32'hffffffff);
      rd_chk(`MSW_IDX_IRQ_STATUS_1, 32'h0);
      pulse(3'h0, 32'h00000008, 32'h80000000);
      rd_chk(`MSW_IDX_IRQ_STATUS_0, 32'h00000008);
      rd_chk(`MSW_IDX_IRQ_STATUS_1, 32'h80000000);
      irq_chk(32'h0);
      wr(`MSW_IDX_IRQ_ENABLE_0, 32'h00000008);
      irq_chk(32'h1);
      wr(`MSW_IDX_IRQ_STATUS_0, 32'h00000008);
      irq_chk(32'h0);
      wr(`MSW_IDX_IRQ_ENABLE_1, 32'h80000000);
      irq_chk(32'h1);
      wr(`MSW_IDX_IRQ_STATUS_1, 32'h80000000);
      irq_chk(32'h0);
      rd_chk(`MSW_IDX_IRQ_STATUS_0, 32'h0);
      $display("interrupt test done");
      end_sim();
   end
endmodule

/* rtl/msw_consts.vh */
/*
 Register indices, reset values, status bit positions and bus codes of
 the metering register bank. Assumes byte address = 4 * index.
*/
`ifndef MSW_CONSTS_VH
`define MSW_CONSTS_VH

`define MSW_IDX_CURRENT_PEAK   16'he500
`define MSW_IDX_VOLTAGE_PEAK   16'he501
`define MSW_IDX_IRQ_STATUS_0   16'he502
`define MSW_IDX_IRQ_STATUS_1   16'he503
`define MSW_IDX_A_CURRENT_MAV  16'he504
`define MSW_IDX_B_CURRENT_MAV  16'he505
`define MSW_IDX_C_CURRENT_MAV  16'he506
`define MSW_IDX_OVERCURRENT    16'he507
`define MSW_IDX_OVERVOLTAGE    16'he508
`define MSW_IDX_VOLTAGE_DIP    16'he509
`define MSW_IDX_IRQ_ENABLE_0   16'he50a
`define MSW_IDX_IRQ_ENABLE_1   16'he50b
`define MSW_IDX_A_CURRENT_WV   16'he50c
`define MSW_IDX_B_CURRENT_WV   16'he50d
`define MSW_IDX_C_CURRENT_WV   16'he50e
`define MSW_IDX_N_CURRENT_WV   16'he50f
`define MSW_IDX_A_VOLTAGE_WV   16'he510
`define MSW_IDX_B_VOLTAGE_WV   16'he511
`define MSW_IDX_C_VOLTAGE_WV   16'he512
`define MSW_IDX_A_ACTIVE       16'he513
`define MSW_IDX_B_ACTIVE       16'he514
`define MSW_IDX_C_ACTIVE       16'he515
`define MSW_IDX_A_REACTIVE     16'he516
`define MSW_IDX_B_REACTIVE     16'he517
`define MSW_IDX_C_REACTIVE     16'he518

`define MSW_RST_OVERCURRENT    24'hffffff
`define MSW_RST_OVERVOLTAGE    24'hffffff
`define MSW_RST_VOLTAGE_DIP    24'h000000
`define MSW_RST_IRQ_ENABLE     32'h00000000
`define MSW_RST_IRQ_STATUS     32'h00000000

`define MSW_ST1_OVERCURRENT    17
`define MSW_ST1_OVERVOLTAGE    18
`define MSW_ST1_VOLTAGE_DIP    19

`define MSW_MODE_NORMAL        2'h0
`define MSW_MODE_REDUCED       2'h1

`define MSW_MAV_LOG2           4

`define MSW_HSIZE_WORD         3'h2
`define MSW_HRESP_OKAY         1'h0

`endif

/* rtl/msw_limit.v */
/*
 Level comparator for one channel: pulses when the magnitude of a new
 sample is above (or, for DIP=1, below) a threshold.
 Assumes sample strobe and inputs come from the same clock domain.
*/
`include "msw_consts.vh"

module msw_limit #(
   parameter DIP = 0
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        valid,
   input  wire [23:0] value,
   input  wire [23:0] level,
   output reg         evt_q
);
   wire [23:0] mag;
   wire        hit;

   // Magnitude of twos-complement sample
   assign mag = value[23] ? (~value + 24'h000001) : value;
   assign hit = (DIP != 0) ? (mag < level) : (mag > level);

   always @(posedge clk) begin
      if (sys_rst) begin
         evt_q <= 1'b0;
      end else begin
         evt_q <= valid & hit;  // [R12]
      end
   end
endmodule

/* rtl/msw_mav.v */
/*
 Mean absolute value of one current channel over 2^MSW_MAV_LOG2 samples.
 Assumes samples arrive with a one-cycle strobe on the same clock.
*/
`include "msw_consts.vh"

module msw_mav (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        run,
   input  wire        valid,
   input  wire [23:0] sample,
   output reg  [19:0] mav_q
);
   reg  [23:0] acc_q;
   reg  [3:0]  cnt_q;
   wire [23:0] mag;
   wire [19:0] term;
   wire [23:0] sum;

   assign mag  = sample[23] ? (~sample + 24'h000001) : sample;
   // Full-scale negative saturates
   assign term = mag[23] ? 20'hfffff : mag[22:3];
   assign sum  = acc_q + {4'h0, term};

   always @(posedge clk) begin
      if (sys_rst) begin
         acc_q <= 24'h000000;
         cnt_q <= 4'h0;
         mav_q <= 20'h00000;
      end else if (!run) begin
         acc_q <= 24'h000000;
         cnt_q <= 4'h0;
      end else if (valid) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'hf) begin
            mav_q <= sum[23:`MSW_MAV_LOG2];  // [R5]
            acc_q <= 24'h000000;
         end else begin
            acc_q <= sum;
         end
      end
   end
endmodule

/* rtl/msw_regs.v */
/*
 Metering status and waveform register bank, AHB-Lite slave.
 Assumes the signal-processing engine drives samples, powers, peaks and
 events on clk with one-cycle valid strobes; single word transfers.
*/
// Local design decision: the AHB-Lite slave port.
// Overview of operation
// R1: Read-only 32-bit current peak register holds captured peak current.
// R2: Read-only 32-bit voltage peak register follows the current peak.
// R3: Two read/write 32-bit interrupt status registers at consecutive locations.
// R4: Two read/write interrupt enable registers reset to zero.
// R5: Per-phase 20-bit current mean absolute value in the two measuring modes.
// R6: 24-bit read/write voltage dip threshold resets to zero.
// R7: Read-only 24-bit signed current, neutral and voltage samples.
// R8: Read-only 24-bit signed active power per phase, three consecutive.
// R9: Read-only 24-bit signed reactive power per phase, three consecutive.
// R10: 24- and 20-bit unsigned values read with zeros in upper bits.
// R11: Host must not write reserved locations.
// R12: Overcurrent and overvoltage thresholds reset to all ones.
// R13: Signed 24-bit values read with the sign copied into upper bits.
`include "msw_consts.vh"

module msw_regs (
   input  wire         clk,
   input  wire         sys_rst,
   input  wire         hsel,
   input  wire [31:0]  haddr,
   input  wire [1:0]   htrans,
   input  wire         hwrite,
   input  wire [2:0]   hsize,
   input  wire         hready,
   input  wire [31:0]  hwdata,
   output reg          hreadyout,
   output reg          hresp,
   output reg  [31:0]  hrdata,
   output reg          irq_q,
   input  wire [1:0]   power_mode,
   input  wire         sample_valid,
   input  wire [23:0]  ia_sample,
   input  wire [23:0]  ib_sample,
   input  wire [23:0]  ic_sample,
   input  wire [23:0]  in_sample,
   input  wire [23:0]  va_sample,
   input  wire [23:0]  vb_sample,
   input  wire [23:0]  vc_sample,
   input  wire         power_valid,
   input  wire [23:0]  a_active_in,
   input  wire [23:0]  b_active_in,
   input  wire [23:0]  c_active_in,
   input  wire [23:0]  a_reactive_in,
   input  wire [23:0]  b_reactive_in,
   input  wire [23:0]  c_reactive_in,
   input  wire         peak_valid,
   input  wire [31:0]  current_peak_in,
   input  wire [31:0]  voltage_peak_in,
   input  wire [31:0]  event0,
   input  wire [31:0]  event1,
   output reg  [23:0]  overcurrent_level_q,
   output reg  [23:0]  overvoltage_level_q,
   output reg  [23:0]  voltage_dip_level_q
);
   reg  [31:0] current_peak_q;
   reg  [31:0] voltage_peak_q;
   reg  [31:0] irq_status_0_q;
   reg  [31:0] irq_status_1_q;
   reg  [31:0] irq_enable_0_q;
   reg  [31:0] irq_enable_1_q;
   reg  [23:0] wave_q [0:6];
   reg  [23:0] power_q [0:5];
   reg         wr_pend_q;
   reg  [15:0] wr_idx_q;
   reg  [31:0] rd_data;
   reg  [31:0] irq_status_0_d;
   reg  [31:0] irq_status_1_d;
   reg  [31:0] clr0;
   reg  [31:0] clr1;
   reg  [31:0] int_event1;
   wire [19:0] mav [0:2];
   wire [2:0]  oc_evt;
   wire [2:0]  ov_evt;
   wire [2:0]  dip_evt;
   wire [23:0] wave_in [0:6];
   wire [23:0] power_in [0:5];
   wire        mav_run;
   wire        addr_ok;
   wire        take;
   wire [15:0] idx;
   integer     i;

   assign wave_in[0] = ia_sample;
   assign wave_in[1] = ib_sample;
   assign wave_in[2] = ic_sample;
   assign wave_in[3] = in_sample;
   assign wave_in[4] = va_sample;
   assign wave_in[5] = vb_sample;
   assign wave_in[6] = vc_sample;
   assign power_in[0] = a_active_in;
   assign power_in[1] = b_active_in;
   assign power_in[2] = c_active_in;
   assign power_in[3] = a_reactive_in;
   assign power_in[4] = b_reactive_in;
   assign power_in[5] = c_reactive_in;

   // Word index from byte address; anything else is unmapped
   assign idx     = haddr[17:2];
   assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0)
                    && (hsize == `MSW_HSIZE_WORD);
   assign take    = hsel & htrans[1] & hready;

   // MAV runs only in the normal and reduced power modes
   assign mav_run = (power_mode == `MSW_MODE_NORMAL) ||
                    (power_mode == `MSW_MODE_REDUCED);

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_phase
         msw_mav u_mav (
            .clk     (clk),
            .sys_rst (sys_rst),
            .run     (mav_run),
            .valid   (sample_valid),
            .sample  (wave_in[g]),
            .mav_q   (mav[g])
         );
         msw_limit #(.DIP(0)) u_oc (
            .clk     (clk),
            .sys_rst (sys_rst),
            .valid   (sample_valid),
            .value   (wave_in[g]),
            .level   (overcurrent_level_q),
            .evt_q   (oc_evt[g])
         );
         msw_limit #(.DIP(0)) u_ov (
            .clk     (clk),
            .sys_rst (sys_rst),
            .valid   (sample_valid),
            .value   (wave_in[g + 4]),
            .level   (overvoltage_level_q),
            .evt_q   (ov_evt[g])
         );
         msw_limit #(.DIP(1)) u_dip (
            .clk     (clk),
            .sys_rst (sys_rst),
            .valid   (sample_valid),
            .value   (wave_in[g + 4]),
            .level   (voltage_dip_level_q),
            .evt_q   (dip_evt[g])
         );
      end
   endgenerate

   // Captured engine values
   always @(posedge clk) begin
      if (sys_rst) begin
         current_peak_q <= 32'h00000000;
         voltage_peak_q <= 32'h00000000;
         for (i = 0; i < 7; i = i + 1) begin
            wave_q[i] <= 24'h000000;
         end
         for (i = 0; i < 6; i = i + 1) begin
            power_q[i] <= 24'h000000;
         end
      end else begin
         if (peak_valid) begin
            current_peak_q <= current_peak_in;  // [R1]
            voltage_peak_q <= voltage_peak_in;  // [R2]
         end
         if (sample_valid) begin
            for (i = 0; i < 7; i = i + 1) begin
               wave_q[i] <= wave_in[i];  // [R7]
            end
         end
         if (power_valid) begin
            for (i = 0; i < 6; i = i + 1) begin
               power_q[i] <= power_in[i];  // [R8] [R9]
            end
         end
      end
   end

   // Status: write one to clear, a new event wins over the clear
   always @* begin
      clr0 = 32'h00000000;
      clr1 = 32'h00000000;
      int_event1 = 32'h00000000;
      int_event1[`MSW_ST1_OVERCURRENT] = |oc_evt;
      int_event1[`MSW_ST1_OVERVOLTAGE] = |ov_evt;
      int_event1[`MSW_ST1_VOLTAGE_DIP] = |dip_evt;
      if (wr_pend_q && (wr_idx_q == `MSW_IDX_IRQ_STATUS_0)) begin
         clr0 = hwdata;
      end
      if (wr_pend_q && (wr_idx_q == `MSW_IDX_IRQ_STATUS_1)) begin
         clr1 = hwdata;
      end
      irq_status_0_d = (irq_status_0_q & ~clr0) | event0;  // [R3]
      irq_status_1_d = (irq_status_1_q & ~clr1) | event1 | int_event1;  // [R3]
   end

   // Read value for the addressed register
   always @* begin
      rd_data = 32'h00000000;
      case (idx)
         `MSW_IDX_CURRENT_PEAK:  rd_data = current_peak_q;  // [R1]
         `MSW_IDX_VOLTAGE_PEAK:  rd_data = voltage_peak_q;  // [R2]
         `MSW_IDX_IRQ_STATUS_0:  rd_data = irq_status_0_q;
         `MSW_IDX_IRQ_STATUS_1:  rd_data = irq_status_1_q;
         `MSW_IDX_A_CURRENT_MAV: rd_data = {12'h000, mav[0]};  // [R5] [R10]
         `MSW_IDX_B_CURRENT_MAV: rd_data = {12'h000, mav[1]};  // [R5] [R10]
         `MSW_IDX_C_CURRENT_MAV: rd_data = {12'h000, mav[2]};  // [R5] [R10]
         `MSW_IDX_OVERCURRENT:   rd_data = {8'h00, overcurrent_level_q};  // [R10]
         `MSW_IDX_OVERVOLTAGE:   rd_data = {8'h00, overvoltage_level_q};  // [R10]
         `MSW_IDX_VOLTAGE_DIP:   rd_data = {8'h00, voltage_dip_level_q};  // [R10]
         `MSW_IDX_IRQ_ENABLE_0:  rd_data = irq_enable_0_q;
         `MSW_IDX_IRQ_ENABLE_1:  rd_data = irq_enable_1_q;
         `MSW_IDX_A_CURRENT_WV:  rd_data = {{8{wave_q[0][23]}}, wave_q[0]};  // [R13]
         `MSW_IDX_B_CURRENT_WV:  rd_data = {{8{wave_q[1][23]}}, wave_q[1]};  // [R13]
         `MSW_IDX_C_CURRENT_WV:  rd_data = {{8{wave_q[2][23]}}, wave_q[2]};  // [R13]
         `MSW_IDX_N_CURRENT_WV:  rd_data = {{8{wave_q[3][23]}}, wave_q[3]};  // [R13]
         `MSW_IDX_A_VOLTAGE_WV:  rd_data = {{8{wave_q[4][23]}}, wave_q[4]};  // [R13]
         `MSW_IDX_B_VOLTAGE_WV:  rd_data = {{8{wave_q[5][23]}}, wave_q[5]};  // [R13]
         `MSW_IDX_C_VOLTAGE_WV:  rd_data = {{8{wave_q[6][23]}}, wave_q[6]};  // [R13]
         `MSW_IDX_A_ACTIVE:      rd_data = {{8{power_q[0][23]}}, power_q[0]};  // [R8]
         `MSW_IDX_B_ACTIVE:      rd_data = {{8{power_q[1][23]}}, power_q[1]};  // [R8]
         `MSW_IDX_C_ACTIVE:      rd_data = {{8{power_q[2][23]}}, power_q[2]};  // [R8]
         `MSW_IDX_A_REACTIVE:    rd_data = {{8{power_q[3][23]}}, power_q[3]};  // [R9]
         `MSW_IDX_B_REACTIVE:    rd_data = {{8{power_q[4][23]}}, power_q[4]};  // [R9]
         `MSW_IDX_C_REACTIVE:    rd_data = {{8{power_q[5][23]}}, power_q[5]};  // [R9]
         default:                rd_data = 32'h00000000;
      endcase
   end

   // Bus slave: zero wait states, always OKAY
   always @(posedge clk) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hresp     <= `MSW_HRESP_OKAY;
         hrdata    <= 32'h00000000;
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 16'h0000;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= `MSW_HRESP_OKAY;
         wr_pend_q <= take & hwrite & addr_ok;
         wr_idx_q  <= idx;
         if (take && !hwrite && addr_ok) begin
            hrdata <= rd_data;
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   // Writable registers; unmapped and read-only words ignore writes
   always @(posedge clk) begin
      if (sys_rst) begin
         irq_status_0_q      <= `MSW_RST_IRQ_STATUS;
         irq_status_1_q      <= `MSW_RST_IRQ_STATUS;
         irq_enable_0_q      <= `MSW_RST_IRQ_ENABLE;  // [R4]
         irq_enable_1_q      <= `MSW_RST_IRQ_ENABLE;  // [R4]
         overcurrent_level_q <= `MSW_RST_OVERCURRENT;  // [R12]
         overvoltage_level_q <= `MSW_RST_OVERVOLTAGE;  // [R12]
         voltage_dip_level_q <= `MSW_RST_VOLTAGE_DIP;  // [R6]
      end else begin
         irq_status_0_q <= irq_status_0_d;
         irq_status_1_q <= irq_status_1_d;
         if (wr_pend_q) begin
            case (wr_idx_q)
               `MSW_IDX_IRQ_ENABLE_0: irq_enable_0_q <= hwdata;  // [R4]
               `MSW_IDX_IRQ_ENABLE_1: irq_enable_1_q <= hwdata;  // [R4]
               `MSW_IDX_OVERCURRENT:  overcurrent_level_q <= hwdata[23:0];  // [R12]
               `MSW_IDX_OVERVOLTAGE:  overvoltage_level_q <= hwdata[23:0];  // [R12]
               `MSW_IDX_VOLTAGE_DIP:  voltage_dip_level_q <= hwdata[23:0];  // [R6]
               default: begin
               end
            endcase
         end
      end
   end

   // Level interrupt from unmasked sticky bits
   always @(posedge clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |((irq_status_0_q & irq_enable_0_q) |
                    (irq_status_1_q & irq_enable_1_q));
      end
   end
endmodule
